// *** dpg_defines.svh ***
// Register offsets, field positions, reset values and widths for the
// shared-pin dual port block.
// Assumes it is included by bare name before the package and modules.
`ifndef DPG_DEFINES_SVH
`define DPG_DEFINES_SVH

// ==========================================================
// Widths
`define DPG_PORT_W 8
`define DPG_ADDR_W 4
`define DPG_BUS_W 16

// ==========================================================
// Register offsets
`define DPG_OFF_LOW_PINS 4'h0
`define DPG_OFF_LOW_LATCH 4'h1
`define DPG_OFF_LOW_DIR 4'h2
`define DPG_OFF_MEMCTL 4'h3
`define DPG_OFF_HIGH_DIR 4'h4
`define DPG_OFF_HIGH_PINS 4'h5
`define DPG_OFF_HIGH_LATCH 4'h6

// ==========================================================
// Memory control register fields
`define DPG_MC_BUS_DIS 7
`define DPG_MC_PROG_SEL 6
`define DPG_MC_WAIT_HI 5
`define DPG_MC_WAIT_LO 4
`define DPG_MC_WIDTH_HI 1
`define DPG_MC_WIDTH_LO 0

// ==========================================================
// Reset and constant values
`define DPG_DIR_RESET 8'hff
`define DPG_BYTE_ZERO 8'h00
`define DPG_BUS_ZERO 16'h0000
`define DPG_PAIR_ZERO 2'h0

`endif

// *** dpg_pkg.sv ***
// Types shared by the shared-pin dual port block.
// Assumes dpg_defines.svh is on the include path.
`include "dpg_defines.svh"

package dpg_pkg;

    // ======================================================
    // Memory control register contents
    typedef struct packed {
        logic bus_dis;
        logic prog_sel;
        logic [1:0] wait_sel;
        logic [1:0] width_sel;
    } dpg_memctl_t;

    // ======================================================
    // State of one port slice
    typedef struct packed {
        logic [`DPG_PORT_W-1:0] dir;
        logic [`DPG_PORT_W-1:0] latch;
        logic [`DPG_PORT_W-1:0] sync1;
        logic [`DPG_PORT_W-1:0] sync2;
        logic [`DPG_PORT_W-1:0] sync3;
        logic [`DPG_PORT_W-1:0] level;
        logic [`DPG_PORT_W-1:0] pin_o;
        logic [`DPG_PORT_W-1:0] pin_oe_b;
    } dpg_port_state_t;

    // ======================================================
    // State of the top level
    typedef struct packed {
        dpg_memctl_t memctl;
        logic [`DPG_PORT_W-1:0] rdata;
        logic [`DPG_BUS_W-1:0] bus_rdata;
    } dpg_top_state_t;

endpackage

// *** dpg_port_if.sv ***
// Carrier between the top level and one port slice.
// Assumes the top decodes registers and the slice owns pins and storage.
`timescale 1ns/1ps
`default_nettype none
`include "dpg_defines.svh"

interface dpg_port_if;
    logic wr_pins;
    logic wr_latch;
    logic wr_dir;
    logic [`DPG_PORT_W-1:0] wdata;
    logic bus_mode;
    logic [`DPG_PORT_W-1:0] bus_out;
    logic [`DPG_PORT_W-1:0] bus_drive;
    logic [`DPG_PORT_W-1:0] dir;
    logic [`DPG_PORT_W-1:0] latch;
    logic [`DPG_PORT_W-1:0] level;

    modport ctl (
        output wr_pins, wr_latch, wr_dir, wdata, bus_mode, bus_out,
        output bus_drive,
        input dir, latch, level
    );

    modport port (
        input wr_pins, wr_latch, wr_dir, wdata, bus_mode, bus_out,
        input bus_drive,
        output dir, latch, level
    );
endinterface

`default_nettype wire

// *** dpg_port_slice.sv ***
// One 8-bit shared port: direction, output latch, pin synchroniser and
// the choice between register drive and system bus drive.
// Assumes pin inputs are asynchronous and the top decodes the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dpg_defines.svh"

module dpg_port_slice
    import dpg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [`DPG_PORT_W-1:0] pin_i,
    output logic [`DPG_PORT_W-1:0] pin_o,
    output logic [`DPG_PORT_W-1:0] pin_oe_b,
    dpg_port_if.port p
);

    dpg_port_state_t state_reg;
    dpg_port_state_t state_next;

    // ======================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        // Three stages; only the second and third vote on a change.
        state_next.sync1 = pin_i;
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        if (state_reg.sync2 == state_reg.sync3) begin
            state_next.level = state_reg.sync3;
        end
        if (p.wr_pins || p.wr_latch) begin
            state_next.latch = p.wdata; // RQ4 RQ13
        end
        if (p.wr_dir) begin
            state_next.dir = p.wdata;
        end
        if (p.bus_mode) begin
            state_next.pin_o = p.bus_out; // RQ12
            state_next.pin_oe_b = ~p.bus_drive; // RQ12
        end else begin
            state_next.pin_o = state_next.latch & ~state_next.dir; // RQ2
            state_next.pin_oe_b = state_next.dir; // RQ1
        end
        if (!rst_b) begin
            // The latch is left alone so its contents survive a reset.
            state_next.dir = `DPG_DIR_RESET; // RQ10 RQ11
            state_next.sync1 = `DPG_BYTE_ZERO;
            state_next.sync2 = `DPG_BYTE_ZERO;
            state_next.sync3 = `DPG_BYTE_ZERO;
            state_next.level = `DPG_BYTE_ZERO;
            state_next.pin_o = `DPG_BYTE_ZERO;
            state_next.pin_oe_b = `DPG_DIR_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    assign pin_o = state_reg.pin_o;
    assign pin_oe_b = state_reg.pin_oe_b;
    assign p.dir = state_reg.dir;
    assign p.latch = state_reg.latch;
    assign p.level = state_reg.level;

    // ======================================================
    // Checks
    a_gpio_drive_dir: assert property (@(posedge mclk) // RQ1
        disable iff (!rst_b)
        !p.bus_mode && !p.wr_dir |=> pin_oe_b == $past(state_reg.dir))
        else $error("Register mode pin enable does not follow direction.");

    a_gpio_drive_val: assert property (@(posedge mclk) // RQ2
        disable iff (!rst_b)
        !p.bus_mode && !p.wr_dir && !p.wr_latch && !p.wr_pins
        |=> pin_o == ($past(state_reg.latch) & ~$past(state_reg.dir)))
        else $error("Register mode pin value does not follow the latch.");

endmodule

`default_nettype wire

// *** dpg_gpio_top.sv ***
// Top of the shared-pin dual port block: register port, memory control
// register, bus pin ownership and the two port slices.
// Assumes a register master on mclk and a bus engine on mclk that
// supplies address, write data and phase for the shared pins.
//
// Notes on behaviour
// RQ1: A direction bit of one turns that pin's driver off so it is input.
// RQ2: A direction bit of zero drives the pin from its output latch bit.
// RQ3: Reading the latch register returns the latch, never the pin level.
// RQ4: Reading the pins register returns pin levels; writing it loads latch.
// RQ5: The ports serve as plain I/O only while the bus-disable bit is set.
// RQ6: In bus mode the low port carries address/data bits seven to zero.
// RQ7: In bus mode the high port carries the high address/data byte.
// RQ8: Sixteen-bit bus mode muxes address and data; eight-bit is address.
// RQ9: After power-on both ports belong to the system bus.
// RQ10: Every direction register resets to all ones on any reset.
// RQ11: The output latches are not set by power-on and kept through resets.
// RQ12: In bus mode direction and latch do not steer the pins.
// RQ13: Pins writes and latch writes land in the same latch storage.
`timescale 1ns/1ps
`default_nettype none
`include "dpg_defines.svh"

module dpg_gpio_top
    import dpg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [`DPG_ADDR_W-1:0] reg_addr,
    input wire logic [`DPG_PORT_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DPG_PORT_W-1:0] reg_rdata,
    input wire logic bus_width_16,
    input wire logic bus_addr_phase,
    input wire logic bus_data_drive,
    input wire logic [`DPG_BUS_W-1:0] bus_addr,
    input wire logic [`DPG_BUS_W-1:0] bus_wdata,
    output logic [`DPG_BUS_W-1:0] bus_rdata,
    output logic ext_bus_enabled,
    output logic program_select_bit,
    output logic [1:0] wait_state_sel,
    output logic [1:0] write_width_sel,
    input wire logic [`DPG_PORT_W-1:0] low_port_pin_i,
    output logic [`DPG_PORT_W-1:0] low_port_pin_o,
    output logic [`DPG_PORT_W-1:0] low_port_pin_oe_b,
    input wire logic [`DPG_PORT_W-1:0] high_port_pin_i,
    output logic [`DPG_PORT_W-1:0] high_port_pin_o,
    output logic [`DPG_PORT_W-1:0] high_port_pin_oe_b
);

    dpg_top_state_t state_reg;
    dpg_top_state_t state_next;
    dpg_port_if low_if();
    dpg_port_if high_if();

    logic bus_mode;
    logic [`DPG_BUS_W-1:0] bus_pin_out;
    logic [`DPG_BUS_W-1:0] bus_pin_drive;
    logic hit_low_pins;
    logic hit_low_latch;
    logic hit_low_dir;
    logic hit_memctl;
    logic hit_high_dir;
    logic hit_high_pins;
    logic hit_high_latch;
    logic [`DPG_PORT_W-1:0] memctl_read;

    // ======================================================
    // Address decode
    assign hit_low_pins = reg_addr == `DPG_OFF_LOW_PINS;
    assign hit_low_latch = reg_addr == `DPG_OFF_LOW_LATCH;
    assign hit_low_dir = reg_addr == `DPG_OFF_LOW_DIR;
    assign hit_memctl = reg_addr == `DPG_OFF_MEMCTL;
    assign hit_high_dir = reg_addr == `DPG_OFF_HIGH_DIR;
    assign hit_high_pins = reg_addr == `DPG_OFF_HIGH_PINS;
    assign hit_high_latch = reg_addr == `DPG_OFF_HIGH_LATCH;

    // ======================================================
    // Pin ownership
    // The pins belong to the bus unless software has set bus-disable.
    assign bus_mode = !state_reg.memctl.bus_dis; // RQ5 RQ9

    always_comb begin
        bus_pin_out = `DPG_BUS_ZERO;
        bus_pin_drive = `DPG_BUS_ZERO;
        if (!bus_width_16) begin
            // Eight-bit mode: the shared pins hold address only.
            bus_pin_out = bus_addr; // RQ8
            bus_pin_drive = ~`DPG_BUS_ZERO; // RQ8
        end else if (bus_addr_phase) begin
            bus_pin_out = bus_addr; // RQ6 RQ7
            bus_pin_drive = ~`DPG_BUS_ZERO; // RQ8
        end else if (bus_data_drive) begin
            bus_pin_out = bus_wdata; // RQ6 RQ7
            bus_pin_drive = ~`DPG_BUS_ZERO; // RQ8
        end
    end

    // ======================================================
    // Slice control
    assign low_if.wr_pins = reg_wr && hit_low_pins;
    assign low_if.wr_latch = reg_wr && hit_low_latch;
    assign low_if.wr_dir = reg_wr && hit_low_dir;
    assign low_if.wdata = reg_wdata;
    assign low_if.bus_mode = bus_mode;
    assign low_if.bus_out = bus_pin_out[`DPG_PORT_W-1:0]; // RQ6
    assign low_if.bus_drive = bus_pin_drive[`DPG_PORT_W-1:0];

    assign high_if.wr_pins = reg_wr && hit_high_pins;
    assign high_if.wr_latch = reg_wr && hit_high_latch;
    assign high_if.wr_dir = reg_wr && hit_high_dir;
    assign high_if.wdata = reg_wdata;
    assign high_if.bus_mode = bus_mode;
    assign high_if.bus_out = bus_pin_out[`DPG_BUS_W-1:`DPG_PORT_W]; // RQ7
    assign high_if.bus_drive = bus_pin_drive[`DPG_BUS_W-1:`DPG_PORT_W];

    dpg_port_slice u_low (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_i(low_port_pin_i),
        .pin_o(low_port_pin_o),
        .pin_oe_b(low_port_pin_oe_b),
        .p(low_if.port)
    );

    dpg_port_slice u_high (
        .mclk(mclk),
        .rst_b(rst_b),
        .pin_i(high_port_pin_i),
        .pin_o(high_port_pin_o),
        .pin_oe_b(high_port_pin_oe_b),
        .p(high_if.port)
    );

    // ======================================================
    // Register file
    // Reserved bits three and two of the memory control register read zero.
    assign memctl_read = {
        state_reg.memctl.bus_dis,
        state_reg.memctl.prog_sel,
        state_reg.memctl.wait_sel,
        `DPG_PAIR_ZERO,
        state_reg.memctl.width_sel
    };

    always_comb begin
        state_next = state_reg;
        state_next.bus_rdata = {high_if.level, low_if.level};
        state_next.rdata = `DPG_BYTE_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                `DPG_OFF_LOW_PINS: begin
                    state_next.rdata = low_if.level; // RQ4
                end
                `DPG_OFF_LOW_LATCH: begin
                    state_next.rdata = low_if.latch; // RQ3
                end
                `DPG_OFF_LOW_DIR: begin
                    state_next.rdata = low_if.dir;
                end
                `DPG_OFF_MEMCTL: begin
                    state_next.rdata = memctl_read;
                end
                `DPG_OFF_HIGH_DIR: begin
                    state_next.rdata = high_if.dir;
                end
                `DPG_OFF_HIGH_PINS: begin
                    state_next.rdata = high_if.level; // RQ4
                end
                `DPG_OFF_HIGH_LATCH: begin
                    state_next.rdata = high_if.latch; // RQ3
                end
                default: begin
                    state_next.rdata = `DPG_BYTE_ZERO;
                end
            endcase
        end
        if (reg_wr && hit_memctl) begin
            state_next.memctl.bus_dis = reg_wdata[`DPG_MC_BUS_DIS];
            state_next.memctl.prog_sel = reg_wdata[`DPG_MC_PROG_SEL];
            state_next.memctl.wait_sel =
                reg_wdata[`DPG_MC_WAIT_HI:`DPG_MC_WAIT_LO];
            state_next.memctl.width_sel =
                reg_wdata[`DPG_MC_WIDTH_HI:`DPG_MC_WIDTH_LO];
        end
        if (!rst_b) begin
            // Every reset hands the pins back to the bus.
            state_next.memctl = '0; // RQ9
            state_next.rdata = `DPG_BYTE_ZERO;
            state_next.bus_rdata = `DPG_BUS_ZERO;
        end
    end

    always_ff @(posedge mclk) begin
        state_reg <= state_next;
    end

    assign reg_rdata = state_reg.rdata;
    assign bus_rdata = state_reg.bus_rdata;
    assign ext_bus_enabled = bus_mode;
    assign program_select_bit = state_reg.memctl.prog_sel;
    assign wait_state_sel = state_reg.memctl.wait_sel;
    assign write_width_sel = state_reg.memctl.width_sel;

    // ======================================================
    // Checks on direction, latch and read-back
    a_dir_reset_low: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> low_if.dir == `DPG_DIR_RESET) // RQ10
        else $error("Low direction did not reset to all ones.");

    a_dir_reset_high: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> high_if.dir == `DPG_DIR_RESET) // RQ10
        else $error("High direction did not reset to all ones.");

    a_reset_pins_input: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ1
        $rose(rst_b) |-> low_port_pin_oe_b == `DPG_DIR_RESET &&
        high_port_pin_oe_b == `DPG_DIR_RESET)
        else $error("Pins driven straight after reset.");

    a_latch_keep_reset: assert property (@(posedge mclk)
        disable iff (1'b0) // RQ11
        !rst_b && $past(rst_b)
        |=> low_if.latch == $past(low_if.latch))
        else $error("Low latch changed across a reset.");

    a_latch_readback: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_rd && hit_low_latch |=> reg_rdata == $past(low_if.latch)) // RQ3
        else $error("Latch read does not return latch contents.");

    a_pins_readback: assert property (@(posedge mclk) disable iff (!rst_b)
        reg_rd && hit_high_pins |=> reg_rdata == $past(high_if.level)) // RQ4
        else $error("Pins read does not return pin levels.");

    a_pins_write_latch: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ4
        reg_wr && hit_low_pins |=> low_if.latch == $past(reg_wdata))
        else $error("Pins write did not load the low latch.");

    a_shared_latch: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ13
        reg_wr && hit_high_pins ##2 reg_rd && hit_high_latch
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("Pins write not visible through latch read.");

    a_rdata_one_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == `DPG_BYTE_ZERO)
        else $error("Read data held outside the answer cycle.");

    // ======================================================
    // Checks on pin ownership
    a_bus_reset_owner: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ9
        $rose(rst_b) |-> ext_bus_enabled ##1 low_port_pin_oe_b ==
        ~$past(bus_pin_drive[`DPG_PORT_W-1:0]))
        else $error("Ports not owned by the bus after reset.");

    a_gpio_only_dis: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ5
        reg_wr && hit_memctl && reg_wdata[`DPG_MC_BUS_DIS]
        |=> !ext_bus_enabled)
        else $error("Bus-disable write did not release the pins.");

    a_bus_ignores_regs: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ12
        bus_mode && bus_width_16 && !bus_addr_phase && !bus_data_drive
        |=> high_port_pin_oe_b == `DPG_DIR_RESET)
        else $error("Register state drove pins during bus mode.");

    a_low_addr_byte: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ6
        bus_mode && bus_width_16 && bus_addr_phase
        |=> low_port_pin_o == $past(bus_addr[`DPG_PORT_W-1:0]) &&
        low_port_pin_oe_b == `DPG_BYTE_ZERO)
        else $error("Low port does not carry the low address byte.");

    a_high_data_byte: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ7
        bus_mode && bus_width_16 && !bus_addr_phase && bus_data_drive
        |=> high_port_pin_o == $past(bus_wdata[`DPG_BUS_W-1:`DPG_PORT_W]))
        else $error("High port does not carry the high data byte.");

    a_addr_only_8bit: assert property (@(posedge mclk)
        disable iff (!rst_b) // RQ8
        rst_b && bus_mode && !bus_width_16
        |=> high_port_pin_o == $past(bus_addr[`DPG_BUS_W-1:`DPG_PORT_W]) &&
        high_port_pin_oe_b == `DPG_BYTE_ZERO)
        else $error("Eight-bit bus mode put data on the pins.");

    a_high_addr_byte: assert property (@(posedge mclk) // RQ7
        disable iff (!rst_b)
        bus_mode && bus_width_16 && bus_addr_phase
        |=> high_port_pin_o ==
        $past(bus_addr[`DPG_BUS_W-1:`DPG_PORT_W]))
        else $error("High port does not carry the high address byte.");

    a_low_data_byte: assert property (@(posedge mclk) // RQ6
        disable iff (!rst_b)
        bus_mode && bus_width_16 && !bus_addr_phase && bus_data_drive
        |=> low_port_pin_o ==
        $past(bus_wdata[`DPG_PORT_W-1:0]))
        else $error("Low port does not carry the low data byte.");

    // Sampled reset in the antecedent keeps the release edge out, since
    // the pins still hold their reset values there.
    a_low_addr_8bit: assert property (@(posedge mclk) // RQ8
        disable iff (!rst_b)
        rst_b && bus_mode && !bus_width_16
        |=> low_port_pin_o ==
        $past(bus_addr[`DPG_PORT_W-1:0]))
        else $error("Eight-bit bus mode lost the low address byte.");

    // ======================================================
    // Checks on memory control, the remaining read paths and the high latch write
    a_memctl_reset: assert property (@(posedge mclk) // RQ9
        disable iff (!rst_b)
        $rose(rst_b) |-> !program_select_bit &&
        wait_state_sel == `DPG_PAIR_ZERO &&
        write_width_sel == `DPG_PAIR_ZERO)
        else $error("Memory control not cleared by reset.");

    a_memctl_write: assert property (@(posedge mclk) // RQ5
        disable iff (!rst_b)
        reg_wr && hit_memctl
        |=> wait_state_sel ==
        $past(reg_wdata[`DPG_MC_WAIT_HI:`DPG_MC_WAIT_LO]))
        else $error("Memory control write did not land.");

    a_dir_readback: assert property (@(posedge mclk) // RQ1
        disable iff (!rst_b)
        reg_rd && hit_low_dir
        |=> reg_rdata == $past(low_if.dir))
        else $error("Direction read does not return direction.");

    a_low_pins_read: assert property (@(posedge mclk) // RQ4
        disable iff (!rst_b)
        reg_rd && hit_low_pins
        |=> reg_rdata == $past(low_if.level))
        else $error("Low pins read does not return pin levels.");

    a_high_latch_read: assert property (@(posedge mclk) // RQ3
        disable iff (!rst_b)
        reg_rd && hit_high_latch
        |=> reg_rdata == $past(high_if.latch))
        else $error("High latch read does not return the latch.");

    a_high_latch_write: assert property (@(posedge mclk) // RQ13
        disable iff (!rst_b)
        reg_wr && hit_high_latch
        |=> high_if.latch == $past(reg_wdata))
        else $error("Latch write did not load the high latch.");

endmodule

`default_nettype wire

// *** dpg_ext_mem.sv ***
// Model of the external memory side of the shared system bus pins.
// Assumes the bench says when the far side drives and with what value.
`timescale 1ns/1ps
`default_nettype none

module dpg_ext_mem (
    input wire logic mclk,
    input wire logic [15:0] dev_o,
    input wire logic [15:0] dev_oe_b,
    input wire logic ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] pin_lvl
);
    logic [15:0] last_reg = 16'h0000;

    // ==========================================================
    // Wire resolution
    // A pin that nobody drives shows the inverse of its last level, so
    // logic that samples a floating pin cannot pass by luck.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!dev_oe_b[i])
                pin_lvl[i] = dev_o[i];
            else if (ext_en)
                pin_lvl[i] = ext_val[i];
            else
                pin_lvl[i] = ~last_reg[i];
        end
    end

    always @(posedge mclk) begin
        last_reg <= pin_lvl;
    end
endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the shared-pin dual port block.
// Assumes the external memory model resolves every shared pin level.
`timescale 1ns/1ps
`default_nettype none
`include "dpg_defines.svh"

module tb;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bw16 = 1'b0;
    logic aph = 1'b0;
    logic ddrv = 1'b0;
    logic [15:0] baddr = 16'h0000;
    logic [15:0] bwdata = 16'h0000;
    logic ext_en = 1'b0;
    logic [15:0] ext_val = 16'h0000;
    logic [7:0] reg_rdata;
    logic [15:0] bus_rdata, pin_o, pin_oe_b, lvl, exp_o;
    logic ebe, psel;
    logic [1:0] wsel, wwid;
    logic [7:0] mlat [0:1];
    logic [7:0] mdir [0:1];
    logic [7:0] mmc;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'haf90;

    dpg_gpio_top i_dpg_gpio_top (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bus_width_16(bw16),
        .bus_addr_phase(aph), .bus_data_drive(ddrv), .bus_addr(baddr),
        .bus_wdata(bwdata), .bus_rdata(bus_rdata), .ext_bus_enabled(ebe),
        .program_select_bit(psel), .wait_state_sel(wsel),
        .write_width_sel(wwid), .low_port_pin_i(lvl[7:0]),
        .low_port_pin_o(pin_o[7:0]), .low_port_pin_oe_b(pin_oe_b[7:0]),
        .high_port_pin_i(lvl[15:8]), .high_port_pin_o(pin_o[15:8]),
        .high_port_pin_oe_b(pin_oe_b[15:8])
    );

    dpg_ext_mem i_dpg_ext_mem (
        .mclk(mclk), .dev_o(pin_o), .dev_oe_b(pin_oe_b),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(lvl)
    );

    // ==========================================================
    // Clock, timeout and helpers
    initial begin
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc > 5000) begin
            error_cnt++;
            test_done();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected pin levels: driven bits show the latch, released bits
    // show what the far side puts on them.
    function automatic logic [15:0] gpio_lvl();
        logic [15:0] v;
        for (int p = 0; p < 2; p++)
            v[p*8 +: 8] = (mlat[p] & ~mdir[p]) | (ext_val[p*8 +: 8] & mdir[p]);
        return v;
    endfunction

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rc(input string n, input logic [3:0] a,
                      input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(n, {8'h00, reg_rdata}, {8'h00, e});
    endtask

    task automatic settle();
        repeat (6) @(posedge mclk);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk("oe_b", pin_oe_b, 16'hffff);
        chk("bus_on", {15'h0000, ebe}, 16'h0001);
        rc("low_dir", `DPG_OFF_LOW_DIR, 8'hff);
        rc("high_dir", `DPG_OFF_HIGH_DIR, 8'hff);
        rc("memctl", `DPG_OFF_MEMCTL, 8'h00);
        for (int p = 0; p < 2; p++) begin
            mlat[p] = 8'(rnd());
            mdir[p] = 8'h00;
        end
        wr(`DPG_OFF_LOW_DIR, 8'h00);
        wr(`DPG_OFF_HIGH_DIR, 8'h00);
        wr(`DPG_OFF_LOW_LATCH, mlat[0]);
        wr(`DPG_OFF_HIGH_LATCH, mlat[1]);
        // Modes: 8-bit address, address phase, data drive, released.
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            bw16 <= (m != 0);
            aph <= (m == 1);
            ddrv <= (m == 2);
            baddr <= 16'(rnd());
            bwdata <= 16'(rnd());
            ext_val <= 16'(rnd());
            ext_en <= (m == 3);
            settle();
            exp_o = (m == 2) ? bwdata : baddr;
            if (m == 3) begin
                chk("bus_rel", pin_oe_b, 16'hffff);
                chk("bus_in", bus_rdata, ext_val);
            end else begin
                chk("bus_oe", pin_oe_b, 16'h0000);
                chk("bus_out", pin_o, exp_o);
                chk("bus_echo", bus_rdata, exp_o);
            end
        end
        mmc = 8'(rnd()) | 8'h80;
        wr(`DPG_OFF_MEMCTL, mmc);
        rc("memctl", `DPG_OFF_MEMCTL, mmc & 8'hf3);
        #1;
        chk("mc_out", {10'h000, ebe, psel, wsel, wwid},
            {10'h000, 1'b0, mmc[6:4], mmc[1:0]});
        for (int k = 0; k < 8; k++) begin
            for (int p = 0; p < 2; p++) begin
                mdir[p] = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'(rnd());
                mlat[p] = 8'(rnd());
                wr(p ? `DPG_OFF_HIGH_DIR : `DPG_OFF_LOW_DIR, mdir[p]);
                if (k % 2)
                    wr(p ? `DPG_OFF_HIGH_PINS : `DPG_OFF_LOW_PINS, mlat[p]);
                else
                    wr(p ? `DPG_OFF_HIGH_LATCH : `DPG_OFF_LOW_LATCH, mlat[p]);
            end
            @(posedge mclk);
            ext_val <= 16'(rnd());
            settle();
            exp_o = gpio_lvl();
            chk("gpio_oe", pin_oe_b, {mdir[1], mdir[0]});
            chk("gpio_o", pin_o,
                {mlat[1] & ~mdir[1], mlat[0] & ~mdir[0]});
            chk("gpio_lvl", bus_rdata, exp_o);
            rc("low_lat", `DPG_OFF_LOW_LATCH, mlat[0]);
            rc("high_lat", `DPG_OFF_HIGH_LATCH, mlat[1]);
            rc("low_pins", `DPG_OFF_LOW_PINS, exp_o[7:0]);
            rc("high_pins", `DPG_OFF_HIGH_PINS, exp_o[15:8]);
        end
        wr(4'h7, 8'hff);
        rc("unmapped", 4'h7, 8'h00);
        rc("unmapped", 4'hf, 8'h00);
        rc("low_lat", `DPG_OFF_LOW_LATCH, mlat[0]);
        // A pins write followed closely by a latch read of a new value.
        mlat[1] = ~mlat[1];
        wr(`DPG_OFF_HIGH_PINS, mlat[1]);
        rc("pins_to_lat", `DPG_OFF_HIGH_LATCH, mlat[1]);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk("rst_bus", {15'h0000, ebe}, 16'h0001);
        rc("low_lat", `DPG_OFF_LOW_LATCH, mlat[0]);
        rc("high_lat", `DPG_OFF_HIGH_LATCH, mlat[1]);
        rc("low_dir", `DPG_OFF_LOW_DIR, 8'hff);
        rc("high_dir", `DPG_OFF_HIGH_DIR, 8'hff);
        test_done();
    end
endmodule

`default_nettype wire
